// *** core/tag_pkg.sv ***
// Constants, types and field layouts of the tag response and anti-collision block
package tag_pkg;
   localparam int unsigned   CLK_HZ          = 40000000;
   localparam int unsigned   CARRIER_HZ      = 13560000;
   localparam int unsigned   REPLY_DELAY_FC  = 4352;
   localparam int unsigned   REPLY_DELAY_CYC = int'((longint'(REPLY_DELAY_FC) * CLK_HZ) / CARRIER_HZ);
   localparam int unsigned   DELAY_W         = 16;

   // Request flag fields and command codes
   localparam int unsigned   RQF_INVENTORY   = 2;
   localparam int unsigned   RQF_FAMILY      = 4;
   localparam int unsigned   RQF_SLOTS       = 5;
   localparam int unsigned   RQF_OPTION      = 6;
   localparam logic [7:0]    CMD_INVENTORY   = 8'h01;
   localparam logic [7:0]    CMD_QUIET       = 8'h02;
   localparam logic [7:0]    CMD_BLOCK_LO    = 8'h20;
   localparam logic [7:0]    CMD_BLOCK_HI    = 8'h27;
   localparam logic [7:0]    CMD_GAP         = 8'h24;
   localparam logic [7:0]    MAX_MASK_BITS   = 8'h40;
   localparam logic [3:0]    LAST_SLOT       = 4'hF;

   // Error codes
   localparam logic [7:0]    ERR_NONE        = 8'h00;
   localparam logic [7:0]    ERR_CMD         = 8'h01;
   localparam logic [7:0]    ERR_FORMAT      = 8'h02;
   localparam logic [7:0]    ERR_OPTION      = 8'h03;
   localparam logic [7:0]    ERR_OTHER       = 8'h0F;
   localparam logic [7:0]    ERR_BLOCK       = 8'h10;
   localparam logic [7:0]    ERR_RELOCK      = 8'h11;
   localparam logic [7:0]    ERR_LOCKED      = 8'h12;
   localparam logic [7:0]    ERR_PROG        = 8'h13;
   localparam logic [7:0]    ERR_LOCKVFY     = 8'h14;

   // Register byte offsets and reset values
   localparam logic [7:0]    REG_CTRL        = 8'h00;
   localparam logic [7:0]    REG_ID_LO       = 8'h04;
   localparam logic [7:0]    REG_ID_HI       = 8'h08;
   localparam logic [7:0]    REG_STATUS      = 8'h0C;
   localparam logic [7:0]    REG_RESP        = 8'h10;
   localparam logic [31:0]   CTRL_RESET      = 32'h0000_0001;
   localparam int unsigned   RESP_SEND_BIT   = 8;
   localparam logic [1:0]    HTRANS_NONSEQ   = 2'h2;

   typedef struct packed {
      logic        sof;
      logic        eof;
      logic        crc_ok;
      logic        valid;
      logic [7:0]  data;
   } rx_s;

   typedef struct packed {
      logic        valid;
      logic        last;
      logic [7:0]  data;
   } tx_s;

   typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_WAIT, ST_HOLD, ST_SEND, ST_SLOT} state_e;
endpackage : tag_pkg

// *** core/tag_anticollision.sv ***
// Tag response builder and inventory anti-collision engine with AHB-Lite registers
//
// The register addresses and the AHB-Lite register port were decided locally.
module tag_anticollision #(
   parameter int unsigned REPLY_DELAY = tag_pkg::REPLY_DELAY_CYC
) (
   // Clock and reset
   input  wire logic          hclk,
   input  wire logic          hresetn,
   // AHB-Lite slave
   input  wire logic          hsel,
   input  wire logic [7:0]    haddr,
   input  wire logic [1:0]    htrans,
   input  wire logic          hwrite,
   input  wire logic [2:0]    hsize,
   input  wire logic [31:0]   hwdata,
   input  wire logic          hready,
   output logic      [31:0]   hrdata,
   output logic               hreadyout,
   output logic               hresp,
   // Decoded reader frames
   input  wire tag_pkg::rx_s  rx,
   // Response bytes toward the frame encoder
   output tag_pkg::tx_s       tx,
   input  wire logic          tx_ready
);
   localparam int unsigned DELAY_W_L = tag_pkg::DELAY_W;
   localparam logic [DELAY_W_L-1:0] DELAY_END = DELAY_W_L'(REPLY_DELAY - 1);

   tag_pkg::state_e state;
   logic [31:0]     ctrl;
   logic [63:0]     unique_tag_id;
   logic [7:0]      req_flags;
   logic [7:0]      req_cmd;
   logic [7:0]      req_family;
   logic [7:0]      mask_len;
   logic [63:0]     mask_raw;
   logic [3:0]      byte_cnt;
   logic            byte_ovf;
   logic [3:0]      slot;
   logic            inv_active;
   logic            sixteen;
   logic [DELAY_W_L-1:0] delay_cnt;
   logic            resp_ready;
   logic            resp_err;
   logic [7:0]      resp_code;
   logic [7:0]      last_err;
   logic [3:0]      tx_idx;
   logic            ap_write;
   logic            ap_valid;
   logic [7:0]      ap_addr;

   // Bus decode
   wire             bus_go      = hsel && hready && (htrans == tag_pkg::HTRANS_NONSEQ);
   wire             wr_ctrl     = ap_valid && ap_write && (ap_addr == tag_pkg::REG_CTRL);
   wire             wr_id_lo    = ap_valid && ap_write && (ap_addr == tag_pkg::REG_ID_LO);
   wire             wr_id_hi    = ap_valid && ap_write && (ap_addr == tag_pkg::REG_ID_HI);
   wire             wr_resp     = ap_valid && ap_write && (ap_addr == tag_pkg::REG_RESP);
   wire             enable      = ctrl[0];
   wire  [7:0]      dsfid       = ctrl[15:8];
   wire  [7:0]      family_id   = ctrl[23:16];
   wire  [31:0]     status_word = {last_err, req_cmd, 4'h0, resp_ready, 3'(state), slot, inv_active,
                                   3'h0};
   wire  [31:0]     rd_word     = (haddr == tag_pkg::REG_CTRL)   ? ctrl :
                                  (haddr == tag_pkg::REG_ID_LO)  ? unique_tag_id[31:0] :
                                  (haddr == tag_pkg::REG_ID_HI)  ? unique_tag_id[63:32] :
                                  (haddr == tag_pkg::REG_STATUS) ? status_word : 32'h0000_0000;

   // Request field decode
   wire             is_inv      = req_flags[tag_pkg::RQF_INVENTORY];
   wire             fam_present = req_flags[tag_pkg::RQF_FAMILY];
   wire  [3:0]      hdr_len     = fam_present ? 4'h3 : 4'h2;
   wire             at_len      = is_inv && (byte_cnt == hdr_len);
   wire             at_fam      = is_inv && fam_present && (byte_cnt == 4'h2);
   wire  [3:0]      mask_idx    = byte_cnt - hdr_len - 4'h1;
   wire  [3:0]      mask_bytes  = 4'((mask_len + 8'h07) >> 3);
   wire             len_bad     = (mask_len > tag_pkg::MAX_MASK_BITS);
   wire  [7:0]      cmp_width   = mask_len + (sixteen ? 8'h04 : 8'h00);
   wire             width_bad   = (cmp_width > tag_pkg::MAX_MASK_BITS);
   wire             count_bad   = byte_ovf || (byte_cnt != hdr_len + 4'h1 + mask_bytes);
   wire             cmd_known   = (req_cmd == tag_pkg::CMD_QUIET) ||
                                  ((req_cmd >= tag_pkg::CMD_BLOCK_LO) && (req_cmd <= tag_pkg::CMD_BLOCK_HI) &&
                                   (req_cmd != tag_pkg::CMD_GAP));

   // Slot number placed above the unpadded mask, compared with the low ID bits
   wire  [63:0]     len_keep    = ~(64'hFFFF_FFFF_FFFF_FFFF << mask_len);
   wire  [63:0]     cmp_keep    = ~(64'hFFFF_FFFF_FFFF_FFFF << cmp_width);
   wire  [63:0]     cmp_value   = (mask_raw & len_keep) | ({60'h0, slot} << mask_len);
   wire             id_match    = (((unique_tag_id ^ cmp_value) & cmp_keep) == 64'h0);
   wire             family_ok   = !fam_present || (req_family == family_id);

   // Frame completion classification
   wire             frame_end   = (state == tag_pkg::ST_RX) && rx.eof;
   wire  [7:0]      parse_err   = (byte_cnt < 4'h2)        ? tag_pkg::ERR_FORMAT :
                                  !is_inv && !cmd_known &&
                                  (req_cmd != tag_pkg::CMD_INVENTORY) ? tag_pkg::ERR_CMD :
                                  !is_inv                  ? tag_pkg::ERR_NONE :
                                  (req_cmd != tag_pkg::CMD_INVENTORY) ? tag_pkg::ERR_CMD :
                                  req_flags[tag_pkg::RQF_OPTION] ? tag_pkg::ERR_OPTION :
                                  (len_bad || width_bad || count_bad) ? tag_pkg::ERR_FORMAT :
                                  tag_pkg::ERR_NONE;
   wire             start_inv   = frame_end && rx.crc_ok && enable && is_inv &&
                                  (parse_err == tag_pkg::ERR_NONE) && family_ok;
   wire             start_err   = frame_end && rx.crc_ok && enable && (parse_err != tag_pkg::ERR_NONE);
   wire             start_cmd   = frame_end && rx.crc_ok && enable && !is_inv &&
                                  (parse_err == tag_pkg::ERR_NONE);
   wire             lone_eof    = (state == tag_pkg::ST_SLOT) && rx.eof && !rx.sof;
   wire             last_slot   = !sixteen || (slot == tag_pkg::LAST_SLOT);
   wire             delay_done  = (delay_cnt == DELAY_END);
   wire  [3:0]      tx_count    = inv_active ? 4'h9 : (resp_err ? 4'h1 : 4'h0);
   wire             tx_step     = tx.valid && tx_ready;
   wire             send_done   = tx_step && tx.last;
   wire             software_rq = wr_resp && hwdata[tag_pkg::RESP_SEND_BIT] &&
                                  ((state == tag_pkg::ST_WAIT) || (state == tag_pkg::ST_HOLD)) &&
                                  !inv_active && !resp_ready;

   // Response byte selection: flag, then code or DSFID byte and ID
   wire  [7:0]      flag_byte   = {7'h00, resp_err};
   wire  [3:0]      tx_sel      = tx_step ? (tx_idx + 4'h1) : tx_idx;
   wire  [7:0]      id_byte     = 8'(unique_tag_id >> {tx_sel - 4'h2, 3'h0});
   wire  [7:0]      body_byte   = (tx_sel == 4'h0) ? flag_byte :
                                  resp_err         ? resp_code :
                                  (tx_sel == 4'h1) ? dsfid : id_byte;

   // Next state
   tag_pkg::state_e next_state;
   always_comb begin
      next_state = state;
      case (state)
         tag_pkg::ST_IDLE: begin
            if (rx.sof) begin
               next_state = tag_pkg::ST_RX;
            end
         end
         tag_pkg::ST_RX: begin
            if (rx.eof) begin
               next_state = (start_inv || start_err || start_cmd) ? tag_pkg::ST_WAIT : tag_pkg::ST_IDLE;
            end
         end
         tag_pkg::ST_WAIT: begin
            if (delay_done) begin
               if (inv_active) begin
                  next_state = id_match ? tag_pkg::ST_SEND :
                               (last_slot ? tag_pkg::ST_IDLE : tag_pkg::ST_SLOT);
               end else begin
                  next_state = resp_ready ? tag_pkg::ST_SEND : tag_pkg::ST_HOLD;
               end
            end
         end
         tag_pkg::ST_HOLD: begin
            if (rx.sof) begin
               next_state = tag_pkg::ST_RX;
            end else if (resp_ready) begin
               next_state = tag_pkg::ST_SEND;
            end
         end
         tag_pkg::ST_SEND: begin
            if (send_done) begin
               next_state = (inv_active && !last_slot) ? tag_pkg::ST_SLOT : tag_pkg::ST_IDLE;
            end
         end
         tag_pkg::ST_SLOT: begin
            if (rx.sof) begin
               next_state = tag_pkg::ST_RX;
            end else if (lone_eof) begin
               next_state = tag_pkg::ST_WAIT;
            end
         end
         default: begin
            next_state = tag_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state <= tag_pkg::ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Bus slave: zero wait states, always OKAY, read data captured in the address phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap_valid  <= 1'b0;
         ap_write  <= 1'b0;
         ap_addr   <= 8'h00;
         hrdata    <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         ap_valid  <= bus_go;
         ap_write  <= hwrite;
         ap_addr   <= haddr;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         if (bus_go && !hwrite) begin
            hrdata <= rd_word;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl <= tag_pkg::CTRL_RESET;
         unique_tag_id  <= 64'h0;
      end else begin
         if (wr_ctrl) begin
            ctrl <= hwdata;
         end
         if (wr_id_lo) begin
            unique_tag_id[31:0] <= hwdata;
         end
         if (wr_id_hi) begin
            unique_tag_id[63:32] <= hwdata;
         end
      end
   end

   // Request capture, bytes arrive LSB first and low byte first
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         req_flags  <= 8'h00;
         req_cmd    <= 8'h00;
         req_family <= 8'h00;
         mask_len   <= 8'h00;
         mask_raw   <= 64'h0;
         byte_cnt   <= 4'h0;
         byte_ovf   <= 1'b0;
      end else if (rx.sof && (state != tag_pkg::ST_WAIT) && (state != tag_pkg::ST_SEND)) begin
         byte_cnt <= 4'h0;
         byte_ovf <= 1'b0;
         mask_raw <= 64'h0;
         mask_len <= 8'h00;
      end else if ((state == tag_pkg::ST_RX) && rx.valid) begin
         if (byte_cnt == 4'hF) begin
            byte_ovf <= 1'b1;
         end else begin
            byte_cnt <= byte_cnt + 4'h1;
         end
         if (byte_cnt == 4'h0) begin
            req_flags <= rx.data;
         end
         if (byte_cnt == 4'h1) begin
            req_cmd <= rx.data;
         end
         if (at_fam) begin
            req_family <= rx.data;
         end
         if (at_len) begin
            mask_len <= rx.data;
         end
         if (is_inv && (byte_cnt > hdr_len) && (mask_idx < 4'h8)) begin
            mask_raw[mask_idx[2:0]*8 +: 8] <= rx.data;
         end
      end
   end

   // Slot counter, inventory tracking and reply delay
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         slot       <= 4'h0;
         inv_active <= 1'b0;
         sixteen    <= 1'b0;
         delay_cnt  <= '0;
      end else begin
         if (start_inv) begin
            slot       <= 4'h0;
            inv_active <= 1'b1;
            sixteen    <= !req_flags[tag_pkg::RQF_SLOTS];
         end else if (lone_eof) begin
            slot <= slot + 4'h1;
         end else if (frame_end || (next_state == tag_pkg::ST_IDLE)) begin
            inv_active <= 1'b0;
         end
         if (frame_end || lone_eof) begin
            delay_cnt <= '0;
         end else if ((state == tag_pkg::ST_WAIT) && !delay_done) begin
            delay_cnt <= delay_cnt + 1'b1;
         end
      end
   end

   // Response content; block errors 10 to 14 come from software, bad codes become 0F
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         resp_ready <= 1'b0;
         resp_err   <= 1'b0;
         resp_code  <= tag_pkg::ERR_NONE;
         last_err   <= tag_pkg::ERR_NONE;
      end else begin
         if (start_err) begin
            resp_ready <= 1'b1;
            resp_err   <= 1'b1;
            resp_code  <= parse_err;
            last_err   <= parse_err;
         end else if (start_inv || start_cmd) begin
            resp_ready <= 1'b0;
            resp_err   <= 1'b0;
         end else if (software_rq) begin
            resp_ready <= 1'b1;
            resp_err   <= (hwdata[7:0] != tag_pkg::ERR_NONE);
            if ((hwdata[7:0] == tag_pkg::ERR_CMD) || (hwdata[7:0] == tag_pkg::ERR_FORMAT) ||
                (hwdata[7:0] == tag_pkg::ERR_OPTION) || (hwdata[7:0] == tag_pkg::ERR_NONE) ||
                ((hwdata[7:0] >= tag_pkg::ERR_BLOCK) && (hwdata[7:0] <= tag_pkg::ERR_LOCKVFY))) begin
               resp_code <= hwdata[7:0];
               last_err  <= hwdata[7:0];
            end else begin
               resp_code <= tag_pkg::ERR_OTHER;
               last_err  <= tag_pkg::ERR_OTHER;
            end
         end else if (send_done || (rx.sof && (state == tag_pkg::ST_HOLD))) begin
            resp_ready <= 1'b0;
         end
      end
   end

   // Byte stream toward the encoder, held until accepted
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tx     <= '0;
         tx_idx <= 4'h0;
      end else if ((state != tag_pkg::ST_SEND) && (next_state == tag_pkg::ST_SEND)) begin
         tx_idx     <= 4'h0;
         tx.valid   <= 1'b1;
         tx.last    <= (tx_count == 4'h0);
         tx.data    <= flag_byte;
      end else if (tx_step) begin
         if (tx.last) begin
            tx <= '0;
         end else begin
            tx_idx  <= tx_idx + 4'h1;
            tx.data <= body_byte;
            tx.last <= (tx_idx + 4'h1 == tx_count);
         end
      end else if (tx.valid) begin
         tx.data <= body_byte;
      end
   end

   // Checks
   a_flag_upper_zero: assert property (@(posedge hclk) disable iff (!hresetn)
      tx.valid && (tx_idx == 4'h0) && !$rose(tx.valid) |-> (tx.data[7:1] == 7'h00))
      else $error("response flag upper bits not zero");
   a_error_flag_set: assert property (@(posedge hclk) disable iff (!hresetn)
      tx.valid && (tx_idx == 4'h0) && !$rose(tx.valid) |-> (tx.data[0] == resp_err))
      else $error("error flag does not match error state");
   a_error_frame_len: assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(tx.valid) && resp_err |-> !tx.last)
      else $error("error response lacks its code byte");
   a_option_error: assert property (@(posedge hclk) disable iff (!hresetn)
      start_err && req_flags[tag_pkg::RQF_OPTION] && is_inv && (req_cmd == tag_pkg::CMD_INVENTORY) &&
      (byte_cnt >= 4'h2) |=> (resp_code == tag_pkg::ERR_OPTION))
      else $error("option request not answered with code 03");
   a_cmd_error: assert property (@(posedge hclk) disable iff (!hresetn)
      start_err && !is_inv && !cmd_known && (req_cmd != tag_pkg::CMD_INVENTORY) && (byte_cnt >= 4'h2)
      |=> (resp_code == tag_pkg::ERR_CMD))
      else $error("unsupported command not answered with code 01");
   a_slot_clear: assert property (@(posedge hclk) disable iff (!hresetn)
      start_inv |=> (slot == 4'h0) && inv_active)
      else $error("slot counter not cleared by inventory");
   a_slot_step: assert property (@(posedge hclk) disable iff (!hresetn)
      lone_eof |=> (slot == $past(slot) + 4'h1))
      else $error("slot counter did not advance on lone end of frame");
   a_reply_delay: assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(tx.valid) |-> delay_done || (state == tag_pkg::ST_HOLD))
      else $error("reply started before the reply delay");
   a_sof_exits: assert property (@(posedge hclk) disable iff (!hresetn)
      (state == tag_pkg::ST_SLOT) && rx.sof |=> (state == tag_pkg::ST_RX))
      else $error("start of frame did not leave the slot sequence");
   a_no_match_quiet: assert property (@(posedge hclk) disable iff (!hresetn)
      (state == tag_pkg::ST_WAIT) && delay_done && inv_active && !id_match |=> !tx.valid)
      else $error("reply sent in a slot without ID match");
endmodule : tag_anticollision

// *** tb/reader_model.sv ***
// Reader model: sends frames to the tag and takes its reply bytes
module reader_model (
   // Clock
   input  wire logic         hclk,
   // Link toward the tag
   output tag_pkg::rx_s      rx,
   input  wire tag_pkg::tx_s tx,
   output logic              tx_ready
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] got[$];
   initial rx = '0;
   initial tx_ready = 1'b0;
   // Takes offered bytes, stalling every other cycle
   always @(posedge hclk) begin
      if (tx.valid === 1'b1 && tx_ready) got.push_back(tx.data);
      tx_ready <= ~tx_ready;
   end
   // Bytes in order, then end of frame; no bytes and no sof is a lone eof
   task automatic send(input logic [7:0] b[$], input logic sof);
      @(posedge hclk) rx.sof <= sof;
      foreach (b[i]) @(posedge hclk) rx <= '{1'b0, 1'b0, 1'b0, 1'b1, b[i]};
      @(posedge hclk) rx <= '{1'b0, 1'b1, 1'b1, 1'b0, ~rx.data};
      @(posedge hclk) rx <= '{1'b0, 1'b0, 1'b0, 1'b0, ~rx.data};
   endtask : send
endmodule : reader_model

// *** tb/tag_response_and_anticollision_bench.sv ***
// Bench: registers over AHB-Lite, inventory slots and error answers
module tag_response_and_anticollision_bench;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int RD = 20;
   logic         hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [7:0]   haddr = 8'h00;
   logic [1:0]   htrans = 2'h0;
   logic [31:0]  hwdata = 32'h0, hrdata, r;
   logic         hreadyout, hresp, tx_ready;
   tag_pkg::rx_s rx;
   tag_pkg::tx_s tx;
   int           mismatches = 0, samples_checked = 0;
   logic [7:0]   none[$];
   logic [7:0]   idr[$] = '{8'h00, 8'h5A, 8'h35, 8'h32, 8'h54, 8'h76, 8'hD4, 8'hC3, 8'hB2, 8'hA1};
   logic [7:0]   code_in[9] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h05, 8'h01, 8'h02, 8'h03};
   logic [7:0]   code_out[9] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h0F, 8'h01, 8'h02, 8'h03};
   always #12.5 hclk = ~hclk;
   tag_anticollision #(.REPLY_DELAY(RD)) uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .rx(rx), .tx(tx), .tx_ready(tx_ready));
   reader_model rd (.hclk(hclk), .rx(rx), .tx(tx), .tx_ready(tx_ready));
   task automatic tally_and_finish;
      if (mismatches == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : tally_and_finish
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : check
   task automatic wait_rdy;
      int k = 0;
      do begin
         @(posedge hclk);
         k++;
      end while (hreadyout !== 1'b1 && k < 50);
      if (k >= 50) begin
         mismatches++;
         tally_and_finish();
      end
   endtask : wait_rdy
   task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= tag_pkg::HTRANS_NONSEQ;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
      q = hrdata;
      check({31'h0, hresp}, 32'h0);
   endtask : ahb
   task automatic expect_reply(input logic [7:0] e[$], input int dly);
      int n = 0;
      int t = 0;
      while (n < RD + 80 && !(e.size() > 0 && rd.got.size() == e.size())) begin
         @(posedge hclk);
         #1;
         n++;
         if (t == 0 && tx.valid === 1'b1) t = n;
      end
      if (dly > 0) check(t, dly);
      check(rd.got.size(), e.size());
      foreach (e[i]) check(rd.got[i], e[i]);
      rd.got.delete();
   endtask : expect_reply
   task automatic err(input logic [7:0] f[$], input logic [7:0] code);
      rd.send(f, 1'b1);
      expect_reply('{8'h01, code}, RD);
   endtask : err
   initial begin
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      ahb(tag_pkg::REG_CTRL, 1'b0, 32'h0, r);
      check(r, tag_pkg::CTRL_RESET);
      ahb(8'h40, 1'b1, 32'hFFFF_FFFF, r);
      ahb(8'h40, 1'b0, 32'h0, r);
      check(r, 32'h0);
      ahb(tag_pkg::REG_ID_LO, 1'b1, 32'h7654_3235, r);
      ahb(tag_pkg::REG_ID_HI, 1'b1, 32'hA1B2_C3D4, r);
      ahb(tag_pkg::REG_CTRL, 1'b1, 32'h0000_5A01, r);
      ahb(tag_pkg::REG_ID_LO, 1'b0, 32'h0, r);
      check(r, 32'h7654_3235);
      rd.send('{8'h24, 8'h01, 8'h00}, 1'b1);
      expect_reply(idr, RD);
      rd.send('{8'h34, 8'h01, 8'h00, 8'h08, 8'h35}, 1'b1);
      expect_reply(idr, RD);
      rd.send('{8'h34, 8'h01, 8'h7E, 8'h00}, 1'b1);
      expect_reply(none, 0);
      rd.send('{8'h24, 8'h01, 8'h0C, 8'h35, 8'h02}, 1'b1);
      expect_reply(idr, RD);
      err('{8'h04, 8'h07}, 8'h01);
      err('{8'h00, 8'h30}, 8'h01);
      err('{8'h44, 8'h01, 8'h00}, 8'h03);
      err('{8'h24, 8'h01, 8'h41}, 8'h02);
      err('{8'h24, 8'h01, 8'h0C, 8'h35}, 8'h02);
      err('{8'h04}, 8'h02);
      rd.send('{8'h04, 8'h01, 8'h04, 8'h05}, 1'b1);
      for (int s = 0; s < 5; s++) begin
         if (s > 0) rd.send(none, 1'b0);
         if (s == 3) expect_reply(idr, RD);
         else expect_reply(none, 0);
         repeat (RD) @(posedge hclk);
      end
      rd.send('{8'h04, 8'h01, 8'h08, 8'h35}, 1'b1);
      for (int s = 0; s < 3; s++) begin
         if (s > 0) rd.send(none, 1'b0);
         if (s == 2) expect_reply(idr, RD);
         else expect_reply(none, 0);
         repeat (RD) @(posedge hclk);
      end
      for (int i = 0; i < 9; i++) begin
         rd.send('{8'h00, 8'h20, 8'h00}, 1'b1);
         ahb(tag_pkg::REG_RESP, 1'b1, {23'h0, 1'b1, code_in[i]}, r);
         expect_reply('{8'h01, code_out[i]}, 0);
      end
      tally_and_finish();
   end
endmodule : tag_response_and_anticollision_bench
